//--- design/toc_timer.sv
`timescale 1ns/1ps
// Function
// - two 16-bit compare values checked each count
// - compare resets 8000h, only software changes
// - match outside PWM and one-pulse sets flag, drives enabled pin level
// - compare pin latches low during reset
// - flag plus enable plus unmasked requests interrupt
// - flag clears after status read, low access
// - high byte write stops matching until low
// - disabled pin gets no level, flag works
// - divide-by-two sets at count equal compare
// - slower clocks set at compare plus one
// - force copies level, no flag, no interrupt
// - force ignored in one-pulse or PWM
// - one_pulse_select enables one-pulse on channel one
// - trigger edge reloads counter, starts pulse, flags
// - trigger edge may raise capture interrupt
// - capture flag clears after status, low access
// - compare one match ends the pulse
// - one-pulse never sets compare flag one
// - PWM wins over one-pulse when both set
// - no ordinary capture one in one-pulse
// - in one-pulse, channel two flags only, drives no pin
// - counter restarts FFFCh on reset, low write
// - counter clocked by 2, 4, 8 or external
module toc_timer
  import toc_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // timer pins
  input wire logic CAP_IN_1_I,
  input wire logic CAP_IN_2_I,
  input wire logic EXT_CLK_I,
  output logic CMP_PIN_1_O,
  output logic CMP_PIN_2_O,
  output logic CMP_PIN_EN_1_O,
  output logic CMP_PIN_EN_2_O,
  // processor interrupt
  input wire logic IRQ_MASK_I,
  output logic IRQ_O
);

  // all registered state of the timer except the compare values
  typedef struct packed {
    logic [7:0] ctrl_a; // levels, edge, enables
    logic [7:0] ctrl_b; // pin enables, modes, clock
    logic compare_flag_1; // compare flags
    logic compare_flag_2;
    logic capture_flag_1; // capture flags
    logic icf2;
    logic [3:0] arm; // first clear step seen
    logic [15:0] cnt; // free-running counter
    logic [2:0] pre; // prescaler
    logic eval; // counter just advanced
    logic ext_prev; // external clock history
    logic cap_prev1; // capture pin history
    logic cap_prev2;
    logic [15:0] cap1; // capture values
    logic [15:0] cap2;
    logic pin1; // compare pin latches
    logic pin2;
    logic [7:0] prdata; // read data
  } toc_state_s;

  toc_state_s st;
  toc_state_s next_st;

  // bus decode
  logic acc; // access phase
  logic wr; // write completes
  logic rd; // read completes
  logic mapped; // address decodes
  logic [7:0] wbyte; // written byte
  // mode decode
  logic one_pulse_select; // one-pulse active
  logic pwm; // PWM active
  logic plus_one; // slow clock timing
  logic tick; // counter advance
  logic edge1; // capture pin 1 edge
  logic edge2; // capture pin 2 edge
  logic force_wr; // forced transfer write
  // compare channel results
  logic m1;
  logic m2;
  logic [15:0] cmp1;
  logic [15:0] cmp2;
  logic lo1_acc; // channel low-byte accesses
  logic lo2_acc;
  logic cap1_lo_acc;
  logic cap2_lo_acc;
  toc_clk_e clk_sel;

  // bus phase decode
  always_comb begin
    acc = PSEL_I && PENABLE_I;
    wr = acc && PWRITE_I;
    rd = acc && !PWRITE_I;
    wbyte = PWDATA_I[7:0];
    unique case (PADDR_I)
      OFS_CTRL_A, OFS_CTRL_B, OFS_STATUS: mapped = 1'b1;
      OFS_CMP1_HI, OFS_CMP1_LO: mapped = 1'b1;
      OFS_CMP2_HI, OFS_CMP2_LO: mapped = 1'b1;
      OFS_CNT_HI, OFS_CNT_LO: mapped = 1'b1;
      OFS_CAP1_HI, OFS_CAP1_LO: mapped = 1'b1;
      OFS_CAP2_HI, OFS_CAP2_LO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // low-byte accesses, read or write
  assign lo1_acc = acc && (PADDR_I == OFS_CMP1_LO);
  assign lo2_acc = acc && (PADDR_I == OFS_CMP2_LO);
  assign cap1_lo_acc = acc && (PADDR_I == OFS_CAP1_LO);
  assign cap2_lo_acc = acc && (PADDR_I == OFS_CAP2_LO);

  // mode decode, PWM overrides one-pulse
  assign pwm = st.ctrl_b[B_PWM];
  assign one_pulse_select = st.ctrl_b[B_OPM] && !pwm;
  assign clk_sel = toc_clk_e'(st.ctrl_b[B_CLK_LSB +: 2]);
  assign plus_one = (clk_sel != TOC_DIV2);

  // selected edges on the capture pins
  assign edge1 = (CAP_IN_1_I != st.cap_prev1) && (CAP_IN_1_I == st.ctrl_a[A_EDGE1]);
  assign edge2 = (CAP_IN_2_I != st.cap_prev2) && (CAP_IN_2_I == st.ctrl_b[B_EDGE2]);
  assign force_wr = wr && (PADDR_I == OFS_CTRL_A);

  // timer clock from prescaler or external pin
  always_comb begin
    unique case (clk_sel)
      TOC_DIV2: tick = (st.pre[0] == PRE_DIV2[0]);
      TOC_DIV4: tick = (st.pre[1:0] == PRE_DIV4[1:0]);
      TOC_DIV8: tick = (st.pre == PRE_DIV8);
      TOC_EXT: tick = EXT_CLK_I && !st.ext_prev;
    endcase
  end

  // compare channel one
  toc_cmp_chan u_cmp1 (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .wr_hi_i(wr && (PADDR_I == OFS_CMP1_HI)),
    .wr_lo_i(wr && (PADDR_I == OFS_CMP1_LO)),
    .wdata_i(wbyte),
    .cnt_i(st.cnt),
    .eval_i(st.eval),
    .plus_one_i(plus_one),
    .value_o(cmp1),
    .match_o(m1)
  );

  // compare channel two
  toc_cmp_chan u_cmp2 (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .wr_hi_i(wr && (PADDR_I == OFS_CMP2_HI)),
    .wr_lo_i(wr && (PADDR_I == OFS_CMP2_LO)),
    .wdata_i(wbyte),
    .cnt_i(st.cnt),
    .eval_i(st.eval),
    .plus_one_i(plus_one),
    .value_o(cmp2),
    .match_o(m2)
  );

  // next state; clears first so a same-cycle set wins
  always_comb begin
    next_st = st;
    next_st.ext_prev = EXT_CLK_I;
    next_st.cap_prev1 = CAP_IN_1_I;
    next_st.cap_prev2 = CAP_IN_2_I;
    next_st.eval = 1'b0;
    next_st.pre = 3'(st.pre + 3'h1);
    // control writes, force bits never stored
    if (force_wr) begin
      next_st.ctrl_a = wbyte & CTRL_A_WMASK;
    end
    if (wr && (PADDR_I == OFS_CTRL_B)) begin
      next_st.ctrl_b = wbyte;
    end
    // status read arms the flags that are set
    if (rd && (PADDR_I == OFS_STATUS)) begin
      next_st.arm = {st.capture_flag_1, st.compare_flag_1, st.icf2, st.compare_flag_2};
    end
    // second clear step on low-byte access
    if (lo1_acc && st.arm[2]) begin
      next_st.compare_flag_1 = 1'b0;
      next_st.arm[2] = 1'b0;
    end
    if (lo2_acc && st.arm[0]) begin
      next_st.compare_flag_2 = 1'b0;
      next_st.arm[0] = 1'b0;
    end
    if (cap1_lo_acc && st.arm[3]) begin
      next_st.capture_flag_1 = 1'b0;
      next_st.arm[3] = 1'b0;
    end
    if (cap2_lo_acc && st.arm[1]) begin
      next_st.icf2 = 1'b0;
      next_st.arm[1] = 1'b0;
    end
    // counter advance
    if (tick) begin
      next_st.cnt = 16'(st.cnt + 16'h0001);
      next_st.eval = 1'b1;
    end
    // low-byte write restarts the count
    if (wr && (PADDR_I == OFS_CNT_LO)) begin
      next_st.cnt = CNT_RST;
      next_st.pre = PRE_RST;
      next_st.eval = 1'b0;
    end
    // forced transfer, no flag and no interrupt
    if (force_wr && !one_pulse_select && !pwm) begin
      if (wbyte[A_FORCE1] && st.ctrl_b[B_PIN1]) begin
        next_st.pin1 = wbyte[A_LVL1];
      end
      if (wbyte[A_FORCE2] && st.ctrl_b[B_PIN2]) begin
        next_st.pin2 = wbyte[A_LVL2];
      end
    end
    // channel one match
    if (m1) begin
      if (one_pulse_select) begin
        if (st.ctrl_b[B_PIN1]) begin
          next_st.pin1 = st.ctrl_a[A_LVL1];
        end
      end else if (!pwm) begin
        next_st.compare_flag_1 = 1'b1;
        if (st.ctrl_b[B_PIN1]) begin
          next_st.pin1 = st.ctrl_a[A_LVL1];
        end
      end
    end
    // channel two match, no pin in one-pulse
    if (m2 && !pwm) begin
      next_st.compare_flag_2 = 1'b1;
      if (st.ctrl_b[B_PIN2] && !one_pulse_select) begin
        next_st.pin2 = st.ctrl_a[A_LVL2];
      end
    end
    // capture pin two always captures
    if (edge2) begin
      next_st.cap2 = st.cnt;
      next_st.icf2 = 1'b1;
    end
    // capture pin one: trigger or plain capture
    if (edge1) begin
      if (one_pulse_select) begin
        next_st.cnt = CNT_RST;
        next_st.pre = PRE_RST;
        next_st.eval = 1'b0;
        next_st.capture_flag_1 = 1'b1;
        next_st.cap1 = OPM_CAP;
        if (st.ctrl_b[B_PIN1]) begin
          next_st.pin1 = st.ctrl_a[A_LVL2];
        end
      end else if (!pwm) begin
        next_st.cap1 = st.cnt;
        next_st.capture_flag_1 = 1'b1;
      end
    end
    // read data captured in the setup phase
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      unique case (PADDR_I)
        OFS_CTRL_A: next_st.prdata = st.ctrl_a;
        OFS_CTRL_B: next_st.prdata = st.ctrl_b;
        OFS_STATUS: next_st.prdata = {st.capture_flag_1, st.compare_flag_1, st.icf2, st.compare_flag_2, 4'h0};
        OFS_CMP1_HI: next_st.prdata = cmp1[15:8];
        OFS_CMP1_LO: next_st.prdata = cmp1[7:0];
        OFS_CMP2_HI: next_st.prdata = cmp2[15:8];
        OFS_CMP2_LO: next_st.prdata = cmp2[7:0];
        OFS_CNT_HI: next_st.prdata = st.cnt[15:8];
        OFS_CNT_LO: next_st.prdata = st.cnt[7:0];
        OFS_CAP1_HI: next_st.prdata = st.cap1[15:8];
        OFS_CAP1_LO: next_st.prdata = st.cap1[7:0];
        OFS_CAP2_HI: next_st.prdata = st.cap2[15:8];
        OFS_CAP2_LO: next_st.prdata = st.cap2[7:0];
        default: next_st.prdata = 8'h00;
      endcase
    end
  end

  // state register, pins forced low in reset
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= '0;
      st.ctrl_a <= CTRL_RST;
      st.ctrl_b <= CTRL_RST;
      st.cnt <= CNT_RST;
      st.pre <= PRE_RST;
    end else begin
      st <= next_st;
    end
  end

  // bus answers with no wait states
  assign PRDATA_O = {24'h000000, st.prdata};
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc && !mapped;

  // pins and shared interrupt request
  assign CMP_PIN_1_O = st.pin1;
  assign CMP_PIN_2_O = st.pin2;
  assign CMP_PIN_EN_1_O = st.ctrl_b[B_PIN1];
  assign CMP_PIN_EN_2_O = st.ctrl_b[B_PIN2];
  assign IRQ_O = !IRQ_MASK_I && ((st.ctrl_a[A_COMPARE_IRQ_ENABLE] && (st.compare_flag_1 || st.compare_flag_2))
    || (st.ctrl_a[A_CAPTURE_IRQ_ENABLE] && (st.capture_flag_1 || st.icf2)));

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  // first clear step on compare flag one
  sequence s_arm1;
    rd && (PADDR_I == OFS_STATUS) && st.compare_flag_1;
  endsequence
  // second clear step with no new match
  sequence s_lo1;
    lo1_acc && !m1;
  endsequence

  a_flag_clear: assert property (s_arm1 ##[2:3] s_lo1 |=> !st.compare_flag_1)
    else $error("compare flag one not cleared by two-step access");

  a_flag_keep: assert property (lo1_acc && !st.arm[2] && st.compare_flag_1 |=> st.compare_flag_1)
    else $error("compare flag one cleared without status read");

  a_match_flag: assert property (m2 && !pwm |=> st.compare_flag_2)
    else $error("channel two match did not set its flag");

  a_opm_trigger: assert property (one_pulse_select && edge1 |=> st.cnt == CNT_RST && st.capture_flag_1 && st.cap1 == OPM_CAP)
    else $error("one-pulse trigger did not reload counter and capture");

  a_opm_noflag: assert property (one_pulse_select && !st.compare_flag_1 |=> !st.compare_flag_1)
    else $error("compare flag one set in one-pulse mode");

  a_force_quiet: assert property (force_wr && !m1 && !st.compare_flag_1 |=> !st.compare_flag_1)
    else $error("forced transfer set compare flag one");

  a_force_ignore: assert property (force_wr && one_pulse_select && !m1 && !edge1 |=> $stable(st.pin1))
    else $error("force acted in one-pulse mode");

  a_pin_hold: assert property (!m1 && !edge1 && !force_wr |=> $stable(CMP_PIN_1_O))
    else $error("compare pin one changed without cause");

  a_cnt_restart: assert property (wr && (PADDR_I == OFS_CNT_LO) && !(one_pulse_select && edge1) ##1 !tick [*2]
    |-> st.cnt == CNT_RST)
    else $error("counter low write did not restart at FFFCh");

  a_div2_rate: assert property (clk_sel == TOC_DIV2 && tick ##1 clk_sel == TOC_DIV2 |-> !tick)
    else $error("divide-by-two ticked on consecutive cycles");

  a_irq_out: assert property (st.compare_flag_2 && st.ctrl_a[A_COMPARE_IRQ_ENABLE] && !IRQ_MASK_I |-> IRQ_O)
    else $error("pending compare flag did not request interrupt");

endmodule

//--- design/toc_pkg.sv
package toc_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CMP1_HI = 8'h0C;
  localparam logic [7:0] OFS_CMP1_LO = 8'h10;
  localparam logic [7:0] OFS_CMP2_HI = 8'h14;
  localparam logic [7:0] OFS_CMP2_LO = 8'h18;
  localparam logic [7:0] OFS_CNT_HI = 8'h1C;
  localparam logic [7:0] OFS_CNT_LO = 8'h20;
  localparam logic [7:0] OFS_CAP1_HI = 8'h24;
  localparam logic [7:0] OFS_CAP1_LO = 8'h28;
  localparam logic [7:0] OFS_CAP2_HI = 8'h2C;
  localparam logic [7:0] OFS_CAP2_LO = 8'h30;

  // control_reg_a field positions
  localparam int A_LVL1 = 0;
  localparam int A_LVL2 = 1;
  localparam int A_EDGE1 = 2;
  localparam int A_FORCE1 = 3;
  localparam int A_FORCE2 = 4;
  localparam int A_COMPARE_IRQ_ENABLE = 6;
  localparam int A_CAPTURE_IRQ_ENABLE = 7;

  // control_reg_b field positions
  localparam int B_PIN1 = 0;
  localparam int B_PIN2 = 1;
  localparam int B_OPM = 2;
  localparam int B_PWM = 3;
  localparam int B_CLK_LSB = 4;
  localparam int B_EDGE2 = 6;

  // timer_status_reg field positions
  localparam int S_CAPTURE_FLAG_1 = 7;
  localparam int S_COMPARE_FLAG_1 = 6;
  localparam int S_ICF2 = 5;
  localparam int S_COMPARE_FLAG_2 = 4;

  // reset and reload values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hC7;
  localparam logic [15:0] CMP_RST = 16'h8000;
  localparam logic [15:0] CNT_RST = 16'hFFFC;
  localparam logic [15:0] OPM_CAP = 16'hFFFD;
  localparam logic [2:0] PRE_RST = 3'h0;
  localparam logic [2:0] PRE_DIV2 = 3'h1;
  localparam logic [2:0] PRE_DIV4 = 3'h3;
  localparam logic [2:0] PRE_DIV8 = 3'h7;

  // timer_clock_select encodings
  typedef enum logic [1:0] {
    TOC_DIV2,
    TOC_DIV4,
    TOC_DIV8,
    TOC_EXT
  } toc_clk_e;

endpackage

//--- design/toc_cmp_chan.sv
`timescale 1ns/1ps
module toc_cmp_chan
  import toc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // byte writes from software
  input wire logic wr_hi_i,
  input wire logic wr_lo_i,
  input wire logic [7:0] wdata_i,
  // counter and match timing
  input wire logic [15:0] cnt_i,
  input wire logic eval_i,
  input wire logic plus_one_i,
  // results
  output logic [15:0] value_o,
  output logic match_o
);

  // compare value and high-byte inhibit
  typedef struct packed {
    logic [15:0] value;
    logic inhibit;
  } toc_cmp_s;

  toc_cmp_s st;
  toc_cmp_s next_st;
  logic [15:0] target;

  // only software writes touch the value
  always_comb begin
    next_st = st;
    if (wr_hi_i) begin
      next_st.value[15:8] = wdata_i;
      next_st.inhibit = 1'b1;
    end
    if (wr_lo_i) begin
      next_st.value[7:0] = wdata_i;
      next_st.inhibit = 1'b0;
    end
  end

  // value resets to its documented default
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= {CMP_RST, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // slow clocks match one count later
  assign target = plus_one_i ? 16'(st.value + 16'h0001) : st.value;
  assign match_o = eval_i && !st.inhibit && (cnt_i == target);
  assign value_o = st.value;

  a_inhibit_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_hi_i && !wr_lo_i |=> !match_o)
    else $error("match seen right after high byte write");

  a_value_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_hi_i && !wr_lo_i |=> $stable(value_o))
    else $error("compare value changed without a write");

endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import toc_pkg::*;
  // clock, reset and apb drive
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // timer pins and interrupt
  logic cap1 = 1'b0;
  logic cap2 = 1'b0;
  logic ext = 1'b0;
  logic mask = 1'b0;
  logic pin1;
  logic pin2;
  logic pe1; // compare pin enables
  logic pe2;
  logic irq;
  // bookkeeping
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] rv;
  logic se;

  // 50 MHz clock
  always #10ns clk = ~clk;

  // block under test
  toc_timer i_toc_timer (
    .CLOCK_I(clk), .RST_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CAP_IN_1_I(cap1), .CAP_IN_2_I(cap2), .EXT_CLK_I(ext),
    .CMP_PIN_1_O(pin1), .CMP_PIN_2_O(pin2), .CMP_PIN_EN_1_O(pe1), .CMP_PIN_EN_2_O(pe2),
    .IRQ_MASK_I(mask), .IRQ_O(irq)
  );

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  // compare seen against expected
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer: setup, then access held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  // read a register and compare its byte
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), rv, {24'h000000, exp});
  endtask

  // 16-bit compare value, high byte first
  task automatic wcmp(input logic [7:0] hi_a, input logic [15:0] v);
    wr(hi_a, v[15:8]);
    wr(hi_a + 8'h04, v[7:0]);
  endtask

  // external clock ticks, each one rise then a low gap
  task automatic tick(input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      ext <= 1'b1;
      repeat (2) @(posedge clk);
      ext <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // pins and interrupt, sampled mid-cycle once settled
  task automatic pst(input logic e1, input logic e2, input logic eq);
    @(negedge clk);
    chk("pin1", {31'h0, pin1}, {31'h0, e1});
    chk("pin2", {31'h0, pin2}, {31'h0, e2});
    chk("irq", {31'h0, irq}, {31'h0, eq});
  endtask

  // main sequence
  initial begin
    repeat (7) @(posedge clk);
    pst(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    // low byte latched before the first divide-by-two tick, then reset values
    rd(OFS_CNT_LO, 8'hFC);
    rd(OFS_CNT_HI, 8'hFF);
    rd(OFS_CMP1_HI, 8'h80);
    rd(OFS_CMP1_LO, 8'h00);
    rd(OFS_CMP2_HI, 8'h80);
    rd(OFS_CMP2_LO, 8'h00);
    rd(OFS_STATUS, 8'h00);
    xfer(1'b0, 8'h40, 8'h00);
    chk("slverr", {31'h0, se}, 32'h1);
    chk("unmapped data", rv, 32'h0);
    // compare on external clock, pin 2 not enabled
    wr(OFS_CTRL_B, 8'h31);
    wr(OFS_CTRL_A, 8'h43);
    wcmp(OFS_CMP1_HI, 16'h0002);
    wcmp(OFS_CMP2_HI, 16'h0003);
    chk("pin enables", {30'h0, pe2, pe1}, 32'h1);
    wr(OFS_CNT_LO, 8'h00);
    rd(OFS_CNT_LO, 8'hFC);
    tick(6);
    rd(OFS_CNT_LO, 8'h02);
    rd(OFS_STATUS, 8'h00);
    pst(1'b0, 1'b0, 1'b0);
    tick(1);
    pst(1'b1, 1'b0, 1'b1);
    @(posedge clk);
    mask <= 1'b1;
    pst(1'b1, 1'b0, 1'b0);
    @(posedge clk);
    mask <= 1'b0;
    pst(1'b1, 1'b0, 1'b1);
    // low byte access without a status read keeps the flag
    rd(OFS_CMP1_LO, 8'h02);
    rd(OFS_CMP1_HI, 8'h00);
    tick(1);
    rd(OFS_STATUS, 8'h50);
    pst(1'b1, 1'b0, 1'b1);
    rd(OFS_CMP1_LO, 8'h02);
    rd(OFS_STATUS, 8'h10);
    wr(OFS_CMP2_LO, 8'h03);
    rd(OFS_STATUS, 8'h00);
    pst(1'b1, 1'b0, 1'b0);
    // high byte write holds matching off until the low byte
    wr(OFS_CMP1_HI, 8'h00);
    wr(OFS_CNT_LO, 8'h00);
    tick(7);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_CMP1_LO, 8'h04);
    tick(2);
    rd(OFS_STATUS, 8'h50);
    wr(OFS_CMP1_HI, 8'h00);
    rd(OFS_STATUS, 8'h50);
    wr(OFS_CMP1_LO, 8'h04);
    wr(OFS_CMP2_LO, 8'h03);
    rd(OFS_STATUS, 8'h00);
    // forced levels raise no flag
    wr(OFS_CTRL_B, 8'h33);
    wr(OFS_CTRL_A, 8'h4A);
    pst(1'b0, 1'b0, 1'b0);
    chk("pin enables", {30'h0, pe2, pe1}, 32'h3);
    wr(OFS_CTRL_A, 8'h5B);
    pst(1'b1, 1'b1, 1'b0);
    rd(OFS_STATUS, 8'h00);
    // one-pulse: force ignored, inverted pulse on channel 1
    wr(OFS_CTRL_B, 8'h37);
    wr(OFS_CTRL_A, 8'h18);
    pst(1'b1, 1'b1, 1'b0);
    wcmp(OFS_CMP1_HI, 16'h0001);
    wr(OFS_CTRL_A, 8'h85);
    @(posedge clk);
    cap1 <= 1'b1;
    repeat (4) @(posedge clk);
    pst(1'b0, 1'b1, 1'b1);
    rd(OFS_CNT_HI, 8'hFF);
    rd(OFS_CNT_LO, 8'hFC);
    rd(OFS_STATUS, 8'h80);
    rd(OFS_CAP1_HI, 8'hFF);
    rd(OFS_CAP1_LO, 8'hFD);
    rd(OFS_STATUS, 8'h00);
    pst(1'b0, 1'b1, 1'b0);
    tick(5);
    pst(1'b0, 1'b1, 1'b0);
    tick(1);
    pst(1'b1, 1'b1, 1'b0);
    tick(2);
    rd(OFS_STATUS, 8'h10);
    pst(1'b1, 1'b1, 1'b0);
    rd(OFS_CMP2_LO, 8'h03);
    rd(OFS_STATUS, 8'h00);
    // capture pin two still captures on its falling edge in one-pulse
    @(posedge clk);
    cap2 <= 1'b1;
    @(posedge clk);
    cap2 <= 1'b0;
    repeat (2) @(posedge clk);
    rd(OFS_STATUS, 8'h20);
    pst(1'b1, 1'b1, 1'b1);
    rd(OFS_CAP2_HI, 8'h00);
    rd(OFS_CAP2_LO, 8'h04);
    rd(OFS_STATUS, 8'h00);
    // pwm together with one-pulse: trigger has no effect
    @(posedge clk);
    cap1 <= 1'b0;
    wr(OFS_CTRL_B, 8'h3F);
    @(posedge clk);
    cap1 <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_STATUS, 8'h00);
    rd(OFS_CNT_LO, 8'h04);
    // internal prescaler rates, match delay from restart
    wcmp(OFS_CMP1_HI, 16'h0010);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_CTRL_B, 8'h01 | 8'(s << 4));
      wr(OFS_CTRL_A, 8'(s & 1));
      wr(OFS_CNT_LO, 8'h00);
      n = 0;
      while (pin1 !== 1'(s & 1) && n < 400) begin
        @(posedge clk);
        n++;
      end
      chk("match delay lo", 32'(n >= ((s > 0 ? 21 : 20) - 1) * (2 << s) + 1), 32'h1);
      chk("match delay hi", 32'(n <= (s > 0 ? 21 : 20) * (2 << s) + 4), 32'h1);
      rd(OFS_STATUS, 8'h50);
      rd(OFS_CMP1_LO, 8'h10);
      wr(OFS_CMP2_LO, 8'h03);
    end
    summarize();
  end
endmodule
